//--- verif/nvc_array_model.sv
// Behavioural model of the flash and EEPROM arrays behind the controller.
`timescale 1ns/1ps
module nvc_array_model (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Commands from the controller.
	input wire logic start_in,
	input wire logic abort_in,
	// Bench controls.
	input wire logic slow_in,
	input wire logic erased_in,
	// Answers to the controller.
	output logic done_out,
	output logic blank_out
);
	// ****************************************
	// Busy countdown.
	// ****************************************
	logic [5:0] left_r;
	// Count down from each start; an abort shortens the run to its last cycle.
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			left_r <= 6'h00;
		end else if (start_in) begin
			left_r <= slow_in ? 6'h28 : 6'h04;
		end else if (abort_in && left_r > 6'h01) begin
			left_r <= 6'h01;
		end else if (left_r != 6'h00) begin
			left_r <= left_r - 6'h01;
		end
	end
	// Blank is valid only beside done, so it shows the inverse at all other times.
	assign done_out = (left_r == 6'h01);
	assign blank_out = done_out ? erased_in : ~erased_in;
endmodule

//--- verif/nvc_ctrl_tb.sv
// Self-checking bench of the command launch and status controller.
`timescale 1ns/1ps
module nvc_ctrl_tb;
	// ****************************************
	// Signals and counters.
	// ****************************************
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [31:0] pwdata_in = 32'h0;
	logic stop_mode_in = 1'b0;
	logic slow = 1'b0;
	logic erased = 1'b1;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, array_done_in, array_blank_in;
	logic array_start_out, array_abort_out, key_write_out;
	logic [7:0] array_cmd_out, array_data_out, key_data_out;
	logic [15:0] array_addr_out;
	logic [2:0] key_index_out;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int starts = 0;
	int aborts = 0;
	int keys = 0;
	int base;
	logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
	// The clock runs at 50 MHz.
	always #10 clk_in = ~clk_in;
	nvc_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in), .paddr_in(paddr_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .stop_mode_in(stop_mode_in),
		.array_done_in(array_done_in), .array_blank_in(array_blank_in),
		.array_start_out(array_start_out), .array_abort_out(array_abort_out),
		.array_cmd_out(array_cmd_out), .array_addr_out(array_addr_out),
		.array_data_out(array_data_out), .key_write_out(key_write_out),
		.key_index_out(key_index_out), .key_data_out(key_data_out));
	nvc_array_model arr (.clk_in(clk_in), .resetn_in(resetn_in),
		.start_in(array_start_out), .abort_in(array_abort_out), .slow_in(slow),
		.erased_in(erased), .done_out(array_done_in), .blank_out(array_blank_in));
	// Count output pulses and cut a hang short well beyond the expected run.
	always @(posedge clk_in) begin
		cycles++;
		if (array_start_out === 1'b1) starts++;
		if (array_abort_out === 1'b1) aborts++;
		if (key_write_out === 1'b1) keys++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// ****************************************
	// Tasks.
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		// A slave that never answers is a failure, not a silent pass.
		if (pready_out !== 1'b1) begin
			fail_count++;
			$display("wrong value pready expected 1 seen %b", pready_out);
			report_and_stop();
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic st_chk(input logic [31:0] exp);
		apb(1'b0, nvc_pkg::OFF_STATUS, 32'h0);
		check("status", rd, exp);
	endtask
	// Software order: address, data, command code, then the launch write.
	task automatic run_cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
		w(nvc_pkg::OFF_ADDR, {16'h0, a});
		w(nvc_pkg::OFF_DATA, {24'h0, d});
		w(nvc_pkg::OFF_COMMAND, {24'h0, c});
		w(nvc_pkg::OFF_STATUS, 32'h80);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, nvc_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[6] !== 1'b1 && n < 100);
		// A command that never completes ends the run as a failure.
		if (rd[6] !== 1'b1) begin
			fail_count++;
			$display("wrong value complete expected 1 seen %b", rd[6]);
			report_and_stop();
		end
	endtask
	// ****************************************
	// Tests.
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		st_chk(32'hC0);
		apb(1'b0, nvc_pkg::OFF_PROT, 32'h0);
		check("prot", rd, 32'hFF);
		apb(1'b0, 8'h1C, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		$display("test reset done");
		run_cmd(16'h2000, 8'h11, nvc_pkg::CMD_BYTE_PROG);
		st_chk(32'hD0);
		check("starts", starts, 0);
		w(nvc_pkg::OFF_STATUS, 32'h00);
		st_chk(32'hD0);
		w(nvc_pkg::OFF_STATUS, 32'h10);
		st_chk(32'hC0);
		$display("test divider done");
		w(nvc_pkg::OFF_CLKDIV, 32'h13);
		slow <= 1'b1;
		run_cmd(16'h2345, 8'h5A, nvc_pkg::CMD_BYTE_PROG);
		st_chk(32'h80);
		wait_idle();
		check("starts", starts, 1);
		check("cmd", array_cmd_out, nvc_pkg::CMD_BYTE_PROG);
		check("addr", array_addr_out, 32'h2345);
		check("data", array_data_out, 32'h5A);
		$display("test program done");
		slow <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			base = starts;
			run_cmd(16'h3000, 8'h00, codes[i]);
			wait_idle();
			check("status", rd, (codes[i] == nvc_pkg::CMD_BLANK) ? 32'hC4 : 32'hC0);
			check("cmd", array_cmd_out, codes[i]);
			check("starts", starts, base + 1);
		end
		run_cmd(16'h3000, 8'h00, nvc_pkg::CMD_BLANK);
		wait_idle();
		w(nvc_pkg::OFF_STATUS, 32'h4F);
		st_chk(32'hC4);
		erased <= 1'b0;
		run_cmd(16'h3000, 8'h00, nvc_pkg::CMD_BLANK);
		wait_idle();
		check("status", rd, 32'hC0);
		$display("test codes done");
		base = starts;
		run_cmd(16'h3000, 8'h00, 8'h33);
		st_chk(32'hD0);
		check("starts", starts, base);
		w(nvc_pkg::OFF_STATUS, 32'h10);
		w(nvc_pkg::OFF_COMMAND, {24'h0, nvc_pkg::CMD_BYTE_PROG});
		w(nvc_pkg::OFF_STATUS, 32'h80);
		st_chk(32'hD0);
		check("starts", starts, base);
		w(nvc_pkg::OFF_STATUS, 32'h10);
		$display("test refusals done");
		slow <= 1'b1;
		run_cmd(16'h4000, 8'h01, nvc_pkg::CMD_BURST_PROG);
		run_cmd(16'h4001, 8'h02, nvc_pkg::CMD_BURST_PROG);
		st_chk(32'h00);
		wait_idle();
		check("starts", starts, base + 2);
		check("addr", array_addr_out, 32'h4001);
		base = aborts;
		run_cmd(16'h2000, 8'h00, nvc_pkg::CMD_SECT_ERASE);
		run_cmd(16'h2000, 8'h00, nvc_pkg::CMD_ABORT);
		wait_idle();
		check("aborts", aborts, base + 1);
		check("status", rd, 32'hC0);
		run_cmd(16'h2000, 8'h00, nvc_pkg::CMD_BYTE_PROG);
		stop_mode_in <= 1'b1;
		wait_idle();
		stop_mode_in <= 1'b0;
		check("status", rd, 32'hD0);
		w(nvc_pkg::OFF_STATUS, 32'h10);
		$display("test busy done");
		w(nvc_pkg::OFF_CONFIG, 32'h20);
		base = keys;
		w(nvc_pkg::OFF_ADDR, 32'hFFB3);
		w(nvc_pkg::OFF_DATA, 32'hA7);
		repeat (2) @(posedge clk_in);
		check("keys", keys, base + 1);
		check("key index", key_index_out, 32'h3);
		check("key data", key_data_out, 32'hA7);
		w(nvc_pkg::OFF_CONFIG, 32'h00);
		$display("test key done");
		w(nvc_pkg::OFF_PROT, 32'hFE);
		w(nvc_pkg::OFF_PROT, 32'hFF);
		apb(1'b0, nvc_pkg::OFF_PROT, 32'h0);
		check("prot", rd, 32'hFE);
		base = starts;
		run_cmd(16'hFC00, 8'h01, nvc_pkg::CMD_BYTE_PROG);
		st_chk(32'hE0);
		w(nvc_pkg::OFF_STATUS, 32'h00);
		st_chk(32'hE0);
		w(nvc_pkg::OFF_STATUS, 32'h20);
		st_chk(32'hC0);
		run_cmd(16'h2000, 8'h00, nvc_pkg::CMD_MASS_ERASE);
		st_chk(32'hE0);
		check("starts", starts, base);
		$display("test protection done");
		report_and_stop();
	end
endmodule

//--- verilog/nvc_cmd_buffer.sv
// One-deep holding stage for a burst program command.
`timescale 1ns/1ps
module nvc_cmd_buffer (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Fill and drain.
	input wire logic load_in,
	input wire logic take_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] data_in,
	// Held entry.
	output logic valid_out,
	output logic [15:0] addr_out,
	output logic [7:0] data_out
);
	logic valid_r;
	logic valid_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [7:0] data_r;
	logic [7:0] data_nxt;

	// A load wins over a take so a refill in the drain cycle is kept.
	always_comb begin
		valid_nxt = valid_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		if (take_in) begin
			valid_nxt = 1'b0;
		end
		if (load_in) begin
			valid_nxt = 1'b1;
			addr_nxt = addr_in;
			data_nxt = data_in;
		end
	end

	// Entry registers.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			valid_r <= 1'b0;
			addr_r <= 16'h0000;
			data_r <= 8'h00;
		end else begin
			valid_r <= valid_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	assign valid_out = valid_r;
	assign addr_out = addr_r;
	assign data_out = data_r;
endmodule

//--- verilog/nvc_ctrl.sv
// Command launch and status controller for the flash and EEPROM arrays.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module nvc_ctrl (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// APB slave.
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// System mode.
	input wire logic stop_mode_in,
	// Array side.
	input wire logic array_done_in,
	input wire logic array_blank_in,
	output logic array_start_out,
	output logic array_abort_out,
	output logic [7:0] array_cmd_out,
	output logic [15:0] array_addr_out,
	output logic [7:0] array_data_out,
	// Backdoor key writes.
	output logic key_write_out,
	output logic [2:0] key_index_out,
	output logic [7:0] key_data_out
);
	// ****************************************
	// Declarations.
	// ****************************************
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} nvc_seq_type;
	nvc_seq_type seq_r, seq_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic cbe_r, cbe_nxt, ccf_r, ccf_nxt, pviol_r, pviol_nxt;
	logic accerr_r, accerr_nxt, blank_r, blank_nxt, busy_r, busy_nxt;
	logic [7:0] cmd_r, cmd_nxt, run_cmd_r, run_cmd_nxt;
	logic [15:0] addr_r, addr_nxt, arr_addr_r, arr_addr_nxt;
	logic [7:0] data_r, data_nxt, arr_data_r, arr_data_nxt;
	logic [7:0] clkdiv_r, clkdiv_nxt, prot_r, prot_nxt, config_r, config_nxt;
	logic divset_r, divset_nxt, stop_q_r, stop_q_nxt;
	logic start_r, start_nxt, abort_r, abort_nxt;
	logic key_r, key_nxt;
	logic [2:0] key_idx_r, key_idx_nxt;
	logic [7:0] key_data_r, key_data_nxt;
	logic acc, wr, mapped;
	logic wr_status, launch_wr, launch_ok, legal, is_burst, is_write;
	logic prot_hit, prot_any, buf_valid, buf_load, buf_take;
	logic [15:0] buf_addr;
	logic [7:0] buf_data;
	logic [7:0] status_word;

	// ****************************************
	// Submodules.
	// ****************************************
	nvc_prot_check u_prot (
		.addr_in(addr_r),
		.prot_in(prot_r),
		.hit_out(prot_hit),
		.any_out(prot_any)
	);

	nvc_cmd_buffer u_buf (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.load_in(buf_load),
		.take_in(buf_take),
		.addr_in(addr_r),
		.data_in(data_r),
		.valid_out(buf_valid),
		.addr_out(buf_addr),
		.data_out(buf_data)
	);

	// ****************************************
	// Bus decode.
	// ****************************************
	// A transfer completes in its second access cycle, when ready is high.
	always_comb begin
		acc = psel_in & penable_in & pready_r;
		wr = acc & pwrite_in;
		mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= nvc_pkg::OFF_CONFIG);
		wr_status = wr && (paddr_in == nvc_pkg::OFF_STATUS);
		launch_wr = wr_status && pwdata_in[nvc_pkg::B_CBE];
		launch_ok = launch_wr && (seq_r == SEQ_CMD) && cbe_r;
		status_word = 8'h00;
		status_word[nvc_pkg::B_CBE] = cbe_r;
		status_word[nvc_pkg::B_CCF] = ccf_r;
		status_word[nvc_pkg::B_PVIOL] = pviol_r;
		status_word[nvc_pkg::B_ACCERR] = accerr_r;
		status_word[nvc_pkg::B_BLANK] = blank_r;
	end

	// Command classification.
	always_comb begin
		legal = (cmd_r == nvc_pkg::CMD_BLANK) || (cmd_r == nvc_pkg::CMD_BYTE_PROG)
			|| (cmd_r == nvc_pkg::CMD_BURST_PROG) || (cmd_r == nvc_pkg::CMD_SECT_ERASE)
			|| (cmd_r == nvc_pkg::CMD_MASS_ERASE) || (cmd_r == nvc_pkg::CMD_ABORT);
		is_burst = cmd_r == nvc_pkg::CMD_BURST_PROG;
		is_write = legal && (cmd_r != nvc_pkg::CMD_BLANK) && (cmd_r != nvc_pkg::CMD_ABORT);
	end

	// ****************************************
	// APB answer.
	// ****************************************
	// Read data is captured as ready rises so it is stable for the whole sample.
	always_comb begin
		pready_nxt = psel_in & penable_in & ~pready_r;
		pslverr_nxt = pready_nxt & ~mapped;
		prdata_nxt = prdata_r;
		if (pready_nxt) begin
			prdata_nxt = 32'h00000000;
			unique case (paddr_in)
				nvc_pkg::OFF_STATUS: prdata_nxt[7:0] = status_word;
				nvc_pkg::OFF_COMMAND: prdata_nxt[7:0] = cmd_r;
				nvc_pkg::OFF_ADDR: prdata_nxt[15:0] = addr_r;
				nvc_pkg::OFF_DATA: prdata_nxt[7:0] = data_r;
				nvc_pkg::OFF_CLKDIV: prdata_nxt[7:0] = clkdiv_r;
				nvc_pkg::OFF_PROT: prdata_nxt[7:0] = prot_r;
				nvc_pkg::OFF_CONFIG: prdata_nxt[7:0] = config_r;
				default: prdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ****************************************
	// Command sequencing and status.
	// ****************************************
	// Errors set their flags after any clear in the same cycle, so events win.
	always_comb begin
		seq_nxt = seq_r;
		cmd_nxt = cmd_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		clkdiv_nxt = clkdiv_r;
		prot_nxt = prot_r;
		config_nxt = config_r;
		divset_nxt = divset_r;
		stop_q_nxt = stop_mode_in;
		pviol_nxt = pviol_r;
		accerr_nxt = accerr_r;
		blank_nxt = blank_r;
		busy_nxt = busy_r;
		run_cmd_nxt = run_cmd_r;
		arr_addr_nxt = arr_addr_r;
		arr_data_nxt = arr_data_r;
		start_nxt = 1'b0;
		abort_nxt = 1'b0;
		key_nxt = 1'b0;
		key_idx_nxt = key_idx_r;
		key_data_nxt = key_data_r;
		buf_load = 1'b0;
		buf_take = 1'b0;
		if (wr_status && pwdata_in[nvc_pkg::B_PVIOL]) begin
			pviol_nxt = 1'b0;
		end
		if (wr_status && pwdata_in[nvc_pkg::B_ACCERR]) begin
			accerr_nxt = 1'b0;
		end
		// Array completion; a held burst follows at once.
		if (busy_r && array_done_in) begin
			busy_nxt = 1'b0;
			if (run_cmd_r == nvc_pkg::CMD_BLANK) begin
				blank_nxt = array_blank_in;
			end
			if (buf_valid) begin
				buf_take = 1'b1;
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				arr_addr_nxt = buf_addr;
				arr_data_nxt = buf_data;
			end
		end
		if (stop_mode_in && !stop_q_r && (busy_r || buf_valid)) begin
			accerr_nxt = 1'b1;
		end
		// Register writes other than status.
		if (wr) begin
			unique case (paddr_in)
				nvc_pkg::OFF_CLKDIV: begin
					clkdiv_nxt = pwdata_in[7:0];
					divset_nxt = 1'b1;
				end
				nvc_pkg::OFF_PROT: begin
					// Protection may only grow; a shrinking field is ignored.
					if (pwdata_in[7:6] <= prot_r[7:6]) begin
						prot_nxt[7:6] = pwdata_in[7:6];
					end
					if (pwdata_in[5:0] <= prot_r[5:0]) begin
						prot_nxt[5:0] = pwdata_in[5:0];
					end
				end
				nvc_pkg::OFF_CONFIG: config_nxt = pwdata_in[7:0];
				nvc_pkg::OFF_ADDR: addr_nxt = pwdata_in[15:0];
				nvc_pkg::OFF_DATA: begin
					data_nxt = pwdata_in[7:0];
					if (config_r[nvc_pkg::B_BACKDOOR_KEY_WRITE_ENABLE] && (addr_r >= nvc_pkg::KEY_BASE)
						&& (addr_r <= nvc_pkg::KEY_LAST)) begin
						key_nxt = 1'b1;
						key_idx_nxt = addr_r[2:0];
						key_data_nxt = pwdata_in[7:0];
					end else if (seq_r == SEQ_IDLE && cbe_r) begin
						seq_nxt = SEQ_DATA;
					end else begin
						seq_nxt = SEQ_IDLE;
						accerr_nxt = 1'b1;
					end
				end
				nvc_pkg::OFF_COMMAND: begin
					cmd_nxt = pwdata_in[7:0];
					if (seq_r == SEQ_DATA) begin
						seq_nxt = SEQ_CMD;
					end else begin
						seq_nxt = SEQ_IDLE;
						accerr_nxt = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Launch checks, in order of precedence.
		if (launch_wr) begin
			seq_nxt = SEQ_IDLE;
			if (!launch_ok || !legal) begin
				accerr_nxt = 1'b1;
			end else if (is_write && !divset_r) begin
				accerr_nxt = 1'b1;
			end else if ((cmd_r == nvc_pkg::CMD_MASS_ERASE) ? prot_any
				: (is_write && prot_hit)) begin
				pviol_nxt = 1'b1;
			end else if (cmd_r == nvc_pkg::CMD_ABORT && busy_r) begin
				abort_nxt = run_cmd_r == nvc_pkg::CMD_SECT_ERASE;
				blank_nxt = 1'b0;
			end else if (!busy_nxt) begin
				blank_nxt = 1'b0;
				busy_nxt = 1'b1;
				start_nxt = 1'b1;
				run_cmd_nxt = cmd_r;
				arr_addr_nxt = addr_r;
				arr_data_nxt = data_r;
			end else if (is_burst && run_cmd_r == nvc_pkg::CMD_BURST_PROG && !buf_valid) begin
				blank_nxt = 1'b0;
				buf_load = 1'b1;
			end else begin
				accerr_nxt = 1'b1;
			end
		end
		// The launch write clears the empty flag; it returns once nothing is held.
		cbe_nxt = !launch_wr && !(buf_valid && !buf_take) && !buf_load;
		ccf_nxt = cbe_nxt && !busy_nxt;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seq_r <= SEQ_IDLE;
			cmd_r <= 8'h00;
			addr_r <= 16'h0000;
			data_r <= 8'h00;
			clkdiv_r <= 8'h00;
			prot_r <= nvc_pkg::PROT_RESET;
			config_r <= 8'h00;
			divset_r <= 1'b0;
			stop_q_r <= 1'b0;
			cbe_r <= 1'b1;
			ccf_r <= 1'b1;
			pviol_r <= 1'b0;
			accerr_r <= 1'b0;
			blank_r <= 1'b0;
			busy_r <= 1'b0;
			run_cmd_r <= 8'h00;
			arr_addr_r <= 16'h0000;
			arr_data_r <= 8'h00;
			start_r <= 1'b0;
			abort_r <= 1'b0;
			key_r <= 1'b0;
			key_idx_r <= 3'h0;
			key_data_r <= 8'h00;
		end else begin
			seq_r <= seq_nxt;
			cmd_r <= cmd_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			clkdiv_r <= clkdiv_nxt;
			prot_r <= prot_nxt;
			config_r <= config_nxt;
			divset_r <= divset_nxt;
			stop_q_r <= stop_q_nxt;
			cbe_r <= cbe_nxt;
			ccf_r <= ccf_nxt;
			pviol_r <= pviol_nxt;
			accerr_r <= accerr_nxt;
			blank_r <= blank_nxt;
			busy_r <= busy_nxt;
			run_cmd_r <= run_cmd_nxt;
			arr_addr_r <= arr_addr_nxt;
			arr_data_r <= arr_data_nxt;
			start_r <= start_nxt;
			abort_r <= abort_nxt;
			key_r <= key_nxt;
			key_idx_r <= key_idx_nxt;
			key_data_r <= key_data_nxt;
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	// Every output is a register; the array command follows the running one.
	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r;
	assign array_start_out = start_r;
	assign array_abort_out = abort_r;
	assign array_cmd_out = run_cmd_r;
	assign array_addr_out = arr_addr_r;
	assign array_data_out = arr_data_r;
	assign key_write_out = key_r;
	assign key_index_out = key_idx_r;
	assign key_data_out = key_data_r;

	// ****************************************
	// Assertions.
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_launch_clears_cbe: assert property (launch_wr |=> !cbe_r)
		else $error("launch write did not clear the empty flag");
	chk_ccf_tracks_idle: assert property (ccf_r == (cbe_r && !busy_r && !buf_valid))
		else $error("complete flag does not match idle state");
	chk_ccf_write_none: assert property ((wr_status && !launch_wr && !array_done_in
		&& !busy_r) |=> $stable(ccf_r))
		else $error("status write changed the complete flag");
	chk_pviol_sticky: assert property ((pviol_r && !(wr_status
		&& pwdata_in[nvc_pkg::B_PVIOL])) |=> pviol_r)
		else $error("violation flag cleared without a write of one");
	chk_accerr_hold: assert property ((accerr_r && !(wr_status
		&& pwdata_in[nvc_pkg::B_ACCERR])) |=> accerr_r)
		else $error("access error cleared without a write of one");
	chk_illegal_cmd: assert property ((launch_ok && !legal) |=> accerr_r && !start_r)
		else $error("illegal command was not refused");
	chk_divider_gate: assert property ((launch_ok && is_write && !divset_r)
		|=> accerr_r && !start_r)
		else $error("program before divider setup was not refused");
	chk_prot_refuse: assert property ((launch_ok && legal && divset_r && is_write
		&& prot_hit && !(is_burst && buf_valid)) |=> pviol_r && !start_r)
		else $error("protected command was not discarded");
	chk_blank_keep: assert property ((wr_status && !launch_wr && !busy_r) |=> $stable(blank_r))
		else $error("status write changed the blank flag");
	chk_stop_error: assert property (($rose(stop_mode_in) && busy_r) |=> accerr_r)
		else $error("stop during a command did not flag an error");
	chk_reserved_zero: assert property ((pready_nxt && !pwrite_in && paddr_in
		== nvc_pkg::OFF_STATUS) |=> (prdata_r[3] == 1'b0) && (prdata_r[1:0] == 2'h0))
		else $error("reserved status bits read nonzero");

	cov_burst_held: cover property (buf_load ##[1:200] buf_take);
	cov_blank_pass: cover property (busy_r && run_cmd_r == nvc_pkg::CMD_BLANK
		&& array_done_in && array_blank_in);
	cov_prot_hit: cover property ($rose(pviol_r));
	cov_abort: cover property (abort_r);
endmodule

//--- verilog/nvc_pkg.sv
// Shared constants of the nonvolatile command and status controller.
package nvc_pkg;
	// ****************************************
	// Register byte offsets on the APB.
	// ****************************************
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_COMMAND = 8'h04;
	localparam logic [7:0] OFF_ADDR = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;
	localparam logic [7:0] OFF_CLKDIV = 8'h10;
	localparam logic [7:0] OFF_PROT = 8'h14;
	localparam logic [7:0] OFF_CONFIG = 8'h18;
	// ****************************************
	// Status and configuration bit positions.
	// ****************************************
	localparam int B_CBE = 7;
	localparam int B_CCF = 6;
	localparam int B_PVIOL = 5;
	localparam int B_ACCERR = 4;
	localparam int B_BLANK = 2;
	localparam int B_BACKDOOR_KEY_WRITE_ENABLE = 5;
	// ****************************************
	// Command codes.
	// ****************************************
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
	localparam logic [7:0] CMD_BURST_PROG = 8'h25;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
	localparam logic [7:0] CMD_ABORT = 8'h47;
	// ****************************************
	// Protection map and reset values.
	// ****************************************
	localparam logic [7:0] PROT_RESET = 8'hFF;
	localparam logic [5:0] FPS_NONE = 6'h3F;
	localparam logic [5:0] FPS_ALL = 6'h18;
	localparam logic [1:0] EPS_NONE = 2'h3;
	localparam logic [16:0] FLASH_TOP = 17'h10000;
	localparam logic [16:0] FLASH_STEP = 17'h00600;
	localparam logic [15:0] EE_BASE = 16'h1400;
	localparam logic [15:0] EE_TOP = 16'h1800;
	localparam logic [15:0] EE_STEP = 16'h0010;
	localparam logic [15:0] KEY_BASE = 16'hFFB0;
	localparam logic [15:0] KEY_LAST = 16'hFFB7;
endpackage

//--- verilog/nvc_prot_check.sv
// Protection decision for one array address.
`timescale 1ns/1ps
module nvc_prot_check (
	// Address and protection setting.
	input wire logic [15:0] addr_in,
	input wire logic [7:0] prot_in,
	// Decision.
	output logic hit_out,
	output logic any_out
);
	logic [5:0] fps;
	logic [1:0] eps;
	logic [16:0] fsize;
	logic [15:0] esize;
	logic fhit;
	logic ehit;

	// Protected regions grow down from the top of each array.
	always_comb begin
		fps = prot_in[5:0];
		eps = prot_in[7:6];
		if (fps <= nvc_pkg::FPS_ALL) begin
			fsize = nvc_pkg::FLASH_TOP;
		end else begin
			fsize = 17'((nvc_pkg::FPS_NONE - fps) * nvc_pkg::FLASH_STEP);
		end
		esize = 16'(nvc_pkg::EE_STEP << (2'h3 - eps)) & {16{eps != nvc_pkg::EPS_NONE}};
		fhit = (fsize != 17'h00000) && ({1'b0, addr_in} >= nvc_pkg::FLASH_TOP - fsize);
		ehit = (addr_in >= nvc_pkg::EE_BASE) && (addr_in < nvc_pkg::EE_TOP)
			&& (esize != 16'h0000) && (addr_in >= nvc_pkg::EE_TOP - esize);
		hit_out = fhit | ehit;
		any_out = (fps != nvc_pkg::FPS_NONE) | (eps != nvc_pkg::EPS_NONE);
	end
endmodule
